//--- logic/aocc_pkg.sv
// Package: register map, field positions and decode codes for the clock and output-mode block
package aocc_pkg;

    localparam int unsigned AOCC_DW = 32;
    localparam int unsigned AOCC_AW = 8;

    // Configuration register index; its byte address is four times this
    localparam logic [7:0] AOCC_CFG_OFF = 8'h06;
    // Byte addresses of the select and status words
    localparam logic [7:0] AOCC_IRQSEL_OFF = 8'h08;
    localparam logic [7:0] AOCC_STAT_OFF = 8'h0C;
    localparam logic [7:0] AOCC_WORD_MASK = 8'hFC;

    // Configuration field positions
    localparam int unsigned AOCC_CLK_HI = 15;
    localparam int unsigned AOCC_CLK_LO = 14;
    localparam int unsigned AOCC_DAC1_LINK_BIT = 13;
    localparam int unsigned AOCC_DAC0_LINK_BIT = 12;
    localparam int unsigned AOCC_MODE_HI = 11;
    localparam int unsigned AOCC_MODE_LO = 8;
    localparam int unsigned AOCC_DUAL_BIT = 11;
    localparam int unsigned AOCC_INHIBIT_BIT = 7;
    localparam int unsigned AOCC_ROUTE_BIT = 1;

    // Reset value of the upper byte
    localparam logic [7:0] AOCC_HI_RESET = 8'h00;
    localparam logic [2:0] AOCC_IRQSEL_RESET = 3'h0;

    // Interrupt levels by select code
    localparam logic [3:0] AOCC_LVL_0 = 4'h3;
    localparam logic [3:0] AOCC_LVL_1 = 4'h4;
    localparam logic [3:0] AOCC_LVL_2 = 4'h5;
    localparam logic [3:0] AOCC_LVL_3 = 4'h7;
    localparam logic [3:0] AOCC_LVL_4 = 4'hA;
    localparam logic [3:0] AOCC_LVL_5 = 4'hB;
    localparam logic [3:0] AOCC_LVL_6 = 4'hC;
    localparam logic [3:0] AOCC_LVL_7 = 4'hF;

    // Lower three waveform mode bits
    typedef enum logic [2:0] {
        AOCC_WM_SINGLE = 3'h0,
        AOCC_WM_DMA_SINGLE = 3'h1,
        AOCC_WM_DMA_HALF = 3'h2,
        AOCC_WM_CONT = 3'h3,
        AOCC_WM_CYC_C1 = 3'h4,
        AOCC_WM_CYC_C2 = 3'h5,
        AOCC_WM_CYC_C5 = 3'h6,
        AOCC_WM_PULSED = 3'h7
    } aocc_wmode_t;

endpackage

//--- logic/aocc_cfg_if.sv
// Interface: raw configuration word and line select passed from the register file to the decoders
`timescale 1ns/1ps
`default_nettype none
interface aocc_cfg_if;
    logic [15:0] cfg;
    logic [2:0] irq_sel;

    modport src (output cfg, output irq_sel);
    modport dst (input cfg, input irq_sel);
endinterface
`default_nettype wire

//--- logic/aocc_irq_decode.sv
// Interrupt line select decoder: one-hot level enables
`timescale 1ns/1ps
`default_nettype none
module aocc_irq_decode (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    aocc_cfg_if.dst cfg_in, // Configuration fields
    output logic [3:0] irq_level, // Enabled level number
    output logic [7:0] irq_line_en // One-hot line enable
);
    import aocc_pkg::*;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_level <= AOCC_LVL_0;
            irq_line_en <= 8'h01;
        end else begin
            irq_line_en <= 8'h01 << cfg_in.irq_sel;
            case (cfg_in.irq_sel)
                3'h0: irq_level <= AOCC_LVL_0;
                3'h1: irq_level <= AOCC_LVL_1;
                3'h2: irq_level <= AOCC_LVL_2;
                3'h3: irq_level <= AOCC_LVL_3;
                3'h4: irq_level <= AOCC_LVL_4;
                3'h5: irq_level <= AOCC_LVL_5;
                3'h6: irq_level <= AOCC_LVL_6;
                default: irq_level <= AOCC_LVL_7;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- logic/aocc_mode_decode.sv
// Waveform mode and clock source decoder
`timescale 1ns/1ps
`default_nettype none
module aocc_mode_decode (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    aocc_cfg_if.dst cfg_in, // Configuration fields
    output logic sync_bus_clk_drive, // Internal clock driven to bus
    output logic board_clk_from_bus, // Board clock taken from bus
    output logic timed_irq_en, // Timed interrupts in single mode
    output logic dma_single_req, // DMA request per word
    output logic dma_half_req, // DMA request on half flag
    output logic cont_waveform, // Replay buffer in FIFO
    output logic [2:0] stop_counter_sel, // One-hot: counters 1, 2, 5
    output logic pulsed_waveform, // Counter 2 restarts output
    output logic dual_read_select // One or two reads per update
);
    import aocc_pkg::*;

    aocc_wmode_t wm;
    logic [1:0] clk_mode;

    assign wm = aocc_wmode_t'(cfg_in.cfg[AOCC_MODE_LO+2:AOCC_MODE_LO]);
    assign clk_mode = cfg_in.cfg[AOCC_CLK_HI:AOCC_CLK_LO];

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_bus_clk_drive <= 1'b0;
            board_clk_from_bus <= 1'b0;
        end else begin
            sync_bus_clk_drive <= (clk_mode == 2'h1);
            board_clk_from_bus <= (clk_mode == 2'h3);
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timed_irq_en <= 1'b0;
            dma_single_req <= 1'b0;
            dma_half_req <= 1'b0;
            cont_waveform <= 1'b0;
            stop_counter_sel <= 3'h0;
            pulsed_waveform <= 1'b0;
            dual_read_select <= 1'b0;
        end else begin
            dual_read_select <= cfg_in.cfg[AOCC_DUAL_BIT];
            timed_irq_en <= (wm == AOCC_WM_SINGLE) && cfg_in.cfg[AOCC_DUAL_BIT];
            dma_single_req <= (wm == AOCC_WM_DMA_SINGLE);
            dma_half_req <= (wm == AOCC_WM_DMA_HALF);
            cont_waveform <= (wm == AOCC_WM_CONT);
            stop_counter_sel <= 3'h0;
            pulsed_waveform <= 1'b0;
            case (wm)
                AOCC_WM_CYC_C1: stop_counter_sel <= 3'h1;
                AOCC_WM_CYC_C2: stop_counter_sel <= 3'h2;
                AOCC_WM_CYC_C5: stop_counter_sel <= 3'h4;
                AOCC_WM_PULSED: begin
                    stop_counter_sel <= 3'h1;
                    pulsed_waveform <= 1'b1;
                end
                default: stop_counter_sel <= 3'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- logic/aocc_top.sv
// Clock and analog-output mode configuration register with APB slave
//
// Function
// - Three-bit line select enables interrupt level 3,4,5,7,10,11,12 or 15.
// - Configuration register is 16-bit write-only at byte offset 18 hex (word index 06 hex).
// - Bits 15 to 8 clear at power-up and on reset.
// - Bits 7 to 0 have no reset but act as zero after reset until written; software must initialise them.
// - Clock mode field resets to zero, board on internal 10 MHz.
// - Clock mode: x0 none, 01 drive bus, 11 take board clock from bus.
// - Bit 13 enables serial link into DAC 1.
// - Bit 12 enables serial link into DAC 0.
// - Top mode bit selects one read or data-dependent dual reads per update.
// - Mode 0000 single update; 1000 single update with timed interrupts.
// - Low bits 001 DMA per word; 010 DMA on half flag.
// - Low bits 011 replay continuous waveform from FIFO.
// - Low bits 100, 101, 110 stop by counter 1, 2 or 5.
// - Low bits 111 pulsed: counter 1 stops, counter 2 restarts.
// - Bit 7 inhibits delayed updates and FIFO writes; direct writes pass.
// - Bit 1 routes programmed writes through FIFO; DMA always via FIFO.
`timescale 1ns/1ps
`default_nettype none
module aocc_top (
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [aocc_pkg::AOCC_AW-1:0] paddr, // APB byte address
    input wire logic [aocc_pkg::AOCC_DW-1:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [aocc_pkg::AOCC_DW-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic prog_dac_wr, // Programmed DAC write request
    input wire logic dma_dac_wr, // DMA DAC write request
    input wire logic update_req, // Delayed update request
    output logic fifo_wr_en, // Write into output FIFO
    output logic dac_direct_wr, // Write straight to DAC
    output logic dac_update, // Delayed update to DACs
    output logic sync_bus_clk_drive, // Internal clock onto sync bus
    output logic board_clk_from_bus, // Board clock from sync bus
    output logic dac1_serial_link_en, // DAC 1 serial link on
    output logic dac0_serial_link_en, // DAC 0 serial link on
    output logic [3:0] waveform_mode, // Waveform mode field
    output logic dual_read_select, // Dual-read per update
    output logic timed_irq_en, // Timed interrupts
    output logic dma_single_req, // DMA single requesting
    output logic dma_half_req, // DMA half-flag requesting
    output logic cont_waveform, // Continuous waveform
    output logic [2:0] stop_counter_sel, // Stop counter one-hot
    output logic pulsed_waveform, // Pulsed waveform
    output logic update_inhibit, // Delayed update gate
    output logic fifo_route, // Programmed writes via FIFO
    output logic [7:0] cfg_low, // Raw lower byte
    output logic [3:0] irq_level, // Enabled interrupt level
    output logic [7:0] irq_line_en // One-hot line enable
);
    import aocc_pkg::*;

    logic [7:0] cfg_hi_r;
    logic [7:0] cfg_lo_r;
    logic [2:0] irq_sel_r;
    logic [7:0] word_addr;
    logic hit_cfg;
    logic hit_irq;
    logic hit_stat;
    logic wr_acc;
    logic rd_acc;
    logic lo_written_r;

    aocc_cfg_if cfg_bus ();

    ////////////////////////////////////////////////////////////////////
    // Address decode; zero-wait APB slave
    assign word_addr = paddr & AOCC_WORD_MASK;
    assign hit_cfg = (word_addr == {AOCC_CFG_OFF[5:0], 2'b00});
    assign hit_irq = (word_addr == AOCC_IRQSEL_OFF);
    assign hit_stat = (word_addr == AOCC_STAT_OFF);
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_cfg || hit_irq || hit_stat);

    ////////////////////////////////////////////////////////////////////
    // Upper byte: cleared by reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_hi_r <= AOCC_HI_RESET;
        end else if (wr_acc && hit_cfg && pstrb[1]) begin
            cfg_hi_r <= pwdata[15:8];
        end
    end

    // Lower byte: no reset, holds its value through rst
    always_ff @(posedge clk_sys) begin
        if (wr_acc && hit_cfg && pstrb[0]) begin
            cfg_lo_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lo_written_r <= 1'b0;
        end else if (wr_acc && hit_cfg && pstrb[0]) begin
            lo_written_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_sel_r <= AOCC_IRQSEL_RESET;
        end else if (wr_acc && hit_irq && pstrb[0]) begin
            irq_sel_r <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path: config is write-only and reads zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (hit_irq) begin
                prdata <= {29'h0, irq_sel_r};
            end else if (hit_stat) begin
                prdata <= {27'h0, lo_written_r, irq_level};
            end else begin
                prdata <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Field outputs
    assign cfg_bus.cfg = {cfg_hi_r, cfg_lo_r};
    assign cfg_bus.irq_sel = irq_sel_r;
    assign dac1_serial_link_en = cfg_hi_r[AOCC_DAC1_LINK_BIT-8];
    assign dac0_serial_link_en = cfg_hi_r[AOCC_DAC0_LINK_BIT-8];
    assign waveform_mode = cfg_hi_r[AOCC_MODE_HI-8:AOCC_MODE_LO-8];
    assign update_inhibit = cfg_lo_r[AOCC_INHIBIT_BIT] && lo_written_r;
    assign fifo_route = cfg_lo_r[AOCC_ROUTE_BIT] && lo_written_r;
    assign cfg_low = lo_written_r ? cfg_lo_r : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Write steering and update gating
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fifo_wr_en <= 1'b0;
            dac_direct_wr <= 1'b0;
            dac_update <= 1'b0;
        end else begin
            fifo_wr_en <= (dma_dac_wr || (prog_dac_wr && fifo_route))
                && !update_inhibit;
            dac_direct_wr <= prog_dac_wr && !fifo_route;
            dac_update <= update_req && !update_inhibit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    aocc_mode_decode u_mode (
        .clk_sys(clk_sys),
        .rst(rst),
        .cfg_in(cfg_bus),
        .sync_bus_clk_drive(sync_bus_clk_drive),
        .board_clk_from_bus(board_clk_from_bus),
        .timed_irq_en(timed_irq_en),
        .dma_single_req(dma_single_req),
        .dma_half_req(dma_half_req),
        .cont_waveform(cont_waveform),
        .stop_counter_sel(stop_counter_sel),
        .pulsed_waveform(pulsed_waveform),
        .dual_read_select(dual_read_select)
    );

    aocc_irq_decode u_irq (
        .clk_sys(clk_sys),
        .rst(rst),
        .cfg_in(cfg_bus),
        .irq_level(irq_level),
        .irq_line_en(irq_line_en)
    );
endmodule
`default_nettype wire

//--- testbench/aocc_top_assertions.sv
// Checker: concurrent assertions on the configuration block ports
`timescale 1ns/1ps
`default_nettype none
module aocc_chk import aocc_pkg::*; (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic psel, // Watched
    input wire logic penable, // Watched
    input wire logic pwrite, // Watched
    input wire logic [AOCC_AW-1:0] paddr, // Watched
    input wire logic [AOCC_DW-1:0] pwdata, // Watched
    input wire logic [3:0] pstrb, // Watched
    input wire logic pready, // Watched
    input wire logic pslverr, // Watched
    input wire logic prog_dac_wr, // Watched
    input wire logic update_req, // Watched
    input wire logic dac_direct_wr, // Watched
    input wire logic dac_update, // Watched
    input wire logic fifo_route, // Watched
    input wire logic update_inhibit, // Watched
    input wire logic [3:0] waveform_mode, // Watched
    input wire logic dac1_serial_link_en, // Watched
    input wire logic sync_bus_clk_drive, // Watched
    input wire logic [2:0] stop_counter_sel, // Watched
    input wire logic timed_irq_en, // Watched
    input wire logic [3:0] irq_level, // Watched
    input wire logic [7:0] irq_line_en // Watched
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire [7:0] wa = paddr & AOCC_WORD_MASK;
    wire [7:0] cfg_addr = {AOCC_CFG_OFF[5:0], 2'b00};
    wire mapped = wa == cfg_addr || wa == AOCC_IRQSEL_OFF || wa == AOCC_STAT_OFF;
    wire hw = psel && penable && pwrite && pready && pstrb[1] && wa == cfg_addr;
    ////////////////////////////////////////////////////////////////////////////
    a_pready_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_upper_reset: assert property ($fell(rst) |-> waveform_mode == 4'h0
        && !dac1_serial_link_en && !sync_bus_clk_drive) else $error("upper byte not cleared");
    a_field_write: assert property (hw |=> waveform_mode == $past(pwdata[11:8])
        && dac1_serial_link_en == $past(pwdata[13])) else $error("field not written");
    a_field_hold: assert property (!hw |=> $stable(waveform_mode))
        else $error("mode changed without a write");
    a_clk_decode: assert property (hw |=> ##1
        sync_bus_clk_drive == ($past(pwdata[15:14], 2) == 2'h1)) else $error("clock drive wrong");
    a_stop_decode: assert property (!$past(rst) |-> stop_counter_sel == {
        $past(waveform_mode[2:0]) == 3'h6, $past(waveform_mode[2:0]) == 3'h5,
        $past(waveform_mode[2:0]) == 3'h4 || $past(waveform_mode[2:0]) == 3'h7})
        else $error("stop counter wrong");
    a_timed_irq: assert property (!$past(rst) |->
        timed_irq_en == ($past(waveform_mode) == 4'h8))
        else $error("timed interrupt enable wrong");
    a_direct_wr: assert property (!$past(rst) |->
        dac_direct_wr == $past(prog_dac_wr && !fifo_route))
        else $error("direct write wrong");
    a_update_gate: assert property (!$past(rst) |->
        dac_update == $past(update_req && !update_inhibit))
        else $error("update gate wrong");
    a_irq_low: assert property (irq_line_en == 8'h01 |-> irq_level == AOCC_LVL_0)
        else $error("level for code zero wrong");
    a_irq_top: assert property (irq_line_en == 8'h80 |-> irq_level == AOCC_LVL_7)
        else $error("level for code seven wrong");
endmodule
bind aocc_top aocc_chk chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .pslverr, .prog_dac_wr, .update_req, .dac_direct_wr, .dac_update,
    .fifo_route, .update_inhibit, .waveform_mode, .dac1_serial_link_en,
    .sync_bus_clk_drive, .stop_counter_sel, .timed_irq_en, .irq_level, .irq_line_en);
`default_nettype wire

//--- testbench/aocc_dac_src.sv
// Partner model: host and signal-processor write and update requests
`timescale 1ns/1ps
`default_nettype none
module aocc_dac_src (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic [2:0] req, // Wanted prog, dma, update
    output logic prog_dac_wr, // Programmed write
    output logic dma_dac_wr, // DMA write
    output logic update_req // Update strobe
);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {prog_dac_wr, dma_dac_wr, update_req} <= 3'h0;
        end else begin
            {prog_dac_wr, dma_dac_wr, update_req} <= req;
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Testbench: register writes, field decode and write routing checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import aocc_pkg::*;
    localparam logic [7:0] CFG_ADDR = {AOCC_CFG_OFF[5:0], 2'b00};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00, cfg_low, irq_line_en, lfsr = 8'h48;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0, waveform_mode, irq_level;
    logic [2:0] req = 3'h0, q0, q1, stop_counter_sel;
    logic prog_dac_wr, dma_dac_wr, update_req, fifo_wr_en, dac_direct_wr, dac_update;
    logic sync_bus_clk_drive, board_clk_from_bus, dac1_serial_link_en, dac0_serial_link_en;
    logic dual_read_select, timed_irq_en, dma_single_req, dma_half_req, cont_waveform;
    logic pulsed_waveform, update_inhibit, fifo_route;
    int err_count = 0, comparisons = 0, hi = 0, lo = 0, lw = 0, sel = 0;
    int lv[8] = '{3, 4, 5, 7, 10, 11, 12, 15};
    always #20 clk_sys = ~clk_sys;
    aocc_dac_src src (.clk_sys, .rst, .req, .prog_dac_wr, .dma_dac_wr, .update_req);
    aocc_top uut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .prog_dac_wr, .dma_dac_wr, .update_req, .fifo_wr_en,
        .dac_direct_wr, .dac_update, .sync_bus_clk_drive, .board_clk_from_bus,
        .dac1_serial_link_en, .dac0_serial_link_en, .waveform_mode, .dual_read_select,
        .timed_irq_en, .dma_single_req, .dma_half_req, .cont_waveform, .stop_counter_sel,
        .pulsed_waveform, .update_inhibit, .fifo_route, .cfg_low, .irq_level, .irq_line_en);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic test_done;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            test_done();
        end
        if (w && a == CFG_ADDR && s[1]) hi = d[15:8];
        if (w && a == CFG_ADDR && s[0]) begin
            lo = d[7:0];
            lw = 1;
        end
        if (w && a == AOCC_IRQSEL_OFF) sel = d[2:0];
    endtask
    task automatic cmp;
        int m;
        repeat (3) @(posedge clk_sys);
        #1;
        m = hi & 15;
        chk("wave", m, waveform_mode);
        chk("link1", hi >> 5 & 1, dac1_serial_link_en);
        chk("link0", hi >> 4 & 1, dac0_serial_link_en);
        chk("bus_drv", (hi >> 6) == 1, sync_bus_clk_drive);
        chk("clk_in", (hi >> 6) == 3, board_clk_from_bus);
        chk("dual", m >> 3, dual_read_select);
        chk("timed", m == 8, timed_irq_en);
        chk("dma", {(m & 7) == 1, (m & 7) == 2}, {dma_single_req, dma_half_req});
        chk("cont", (m & 7) == 3, cont_waveform);
        chk("stop", {(m & 7) == 6, (m & 7) == 5, (m & 7) == 4 || (m & 7) == 7},
            stop_counter_sel);
        chk("pulsed", (m & 7) == 7, pulsed_waveform);
        chk("low", lw ? lo : 0, cfg_low);
        chk("inhibit", lw & lo >> 7, update_inhibit);
        chk("route", lw & lo >> 1 & 1, fifo_route);
        chk("level", lv[sel], irq_level);
        chk("line", 1 << sel, irq_line_en);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int v;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        cmp();
        apb(0, AOCC_STAT_OFF, 0, 0);
        chk("status", 32'h3, rd);
        for (int i = 0; i < 16; i++) begin
            lfsr = nxt(lfsr);
            v = {i[1:0], lfsr[1:0], i[3:0], lfsr};
            apb(1, CFG_ADDR, v, 4'h3);
            apb(1, AOCC_IRQSEL_OFF, i, 4'h1);
            cmp();
        end
        apb(0, AOCC_IRQSEL_OFF, 0, 0);
        chk("sel_rd", sel, rd);
        apb(0, AOCC_STAT_OFF, 0, 0);
        chk("status", (lw << 4) | lv[sel], rd);
        // High lane only, then a config read (zero) and an unmapped write (error) leave fields alone
        apb(1, CFG_ADDR, 32'hFFFF_C300, 4'h2);
        apb(0, CFG_ADDR, 0, 0);
        chk("cfg_rd", 0, rd);
        apb(1, 8'h40, 32'h1234, 4'hF);
        chk("err", 1, er);
        cmp();
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        hi = 0;
        lw = 0;
        sel = 0;
        cmp();
        for (int k = 0; k < 4; k++) begin
            apb(1, CFG_ADDR, {k[1], 5'h0, k[0], 1'b0}, 4'h1);
            cmp();
            q0 = req;
            q1 = req;
            for (int j = 0; j < 24; j++) begin
                @(posedge clk_sys);
                lfsr = nxt(lfsr);
                req <= lfsr[2:0];
                #1;
                chk("fifo", (q1[1] | q1[2] & k[0]) & !k[1], fifo_wr_en);
                chk("direct", q1[2] & !k[0], dac_direct_wr);
                chk("update", q1[0] & !k[1], dac_update);
                q1 = q0;
                q0 = req;
            end
        end
        test_done();
    end
endmodule
`default_nettype wire
